// ---- hw/pmf_pin_logic.sv ----
`default_nettype none
`include "pmf_regs.svh"
module pmf_pin_logic (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic nrst,
  // Strap and configuration.
  input wire logic strapMaster,
  input wire pmf_pkg::pmf_cfg_t cfg,
  input wire logic irqPending,
  // RMII transmit inputs from the MAC.
  input wire pmf_pkg::pmf_tx_t txIn,
  // Transmit data passed to the core.
  output logic txValid,
  output logic [1:0] txData,
  // Core status.
  input wire logic refClkIn,
  input wire logic ledIn,
  // Shared clock/indicator pin.
  input wire logic refPinIn,
  output pmf_pkg::pmf_pad_t refPad,
  // Shared irq/sleep pin.
  input wire logic sleepPinIn,
  output logic sleepPinOut,
  output logic sleepPinOe,
  output logic powerDown,
  output logic gpioIn,
  output logic masterMode
);
  import pmf_pkg::*;
  logic hwReset;
  logic strapLoad;
  logic irqMode_q;
  logic master_q;
  pmf_pin_role_t role_q;

  pmf_reset_filter uRst (
    .core_clk(core_clk),
    .nrst(nrst),
    .hwResetQ(hwReset),
    .strapLoad(strapLoad)
  );

  // ==========================================================
  // Strap capture
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      master_q <= 1'b0;
    end
    else if (strapLoad)
    begin
      master_q <= strapMaster;
    end
  end

  // ==========================================================
  // Pin role selection
  function automatic pmf_pin_role_t pickRole(input logic gpio, input logic mst);
    if (gpio)
      pickRole = PMF_PIN_GPIO;
    else if (mst)
      pickRole = PMF_PIN_REFCLK;
    else
      pickRole = PMF_PIN_LED;
  endfunction

  // The role follows the configuration one cycle later, and returns to the default
  // during a qualified reset so that a newly captured strap takes effect cleanly.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      role_q <= PMF_PIN_LED;
    end
    else if (hwReset)
    begin
      role_q <= PMF_PIN_LED;
    end
    else
    begin
      role_q <= pickRole(cfg.gpioSel, master_q);
    end
  end

  // ==========================================================
  // Irq/sleep pin mode
  // Only an explicit write strobe moves the pin into its interrupt role.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      irqMode_q <= `PMF_IRQ_MODE_RST;
    end
    else if (hwReset)
    begin
      irqMode_q <= `PMF_IRQ_MODE_RST;
    end
    else if (cfg.irqModeWr)
    begin
      irqMode_q <= cfg.irqModeVal;
    end
  end

  // ==========================================================
  // Transmit qualification
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      txValid <= 1'b0;
    end
    else
    begin
      txValid <= txIn.en;
    end
  end

  // Data is forced to zero outside enable so that idle dibits never reach the core.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      txData <= 2'h0;
    end
    else
    begin
      txData <= txIn.en ? txIn.data : 2'h0;
    end
  end

  // ==========================================================
  // Strap status
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      masterMode <= 1'b0;
    end
    else
    begin
      masterMode <= master_q;
    end
  end

  // ==========================================================
  // Shared clock/indicator pin
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      gpioIn <= 1'b0;
    end
    else
    begin
      gpioIn <= refPinIn;
    end
  end

  // The clock and indicator roles always drive; only the GPIO role may release the pin.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      refPad <= '0;
    end
    else
    begin
      refPad.in <= 1'b0;
      case (role_q)
        PMF_PIN_REFCLK:
        begin
          refPad.out <= refClkIn;
          refPad.oe <= 1'b1;
        end
        PMF_PIN_GPIO:
        begin
          refPad.out <= cfg.gpioOut;
          refPad.oe <= cfg.gpioOe;
        end
        default:
        begin
          refPad.out <= ledIn;
          refPad.oe <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // Irq/sleep pin
  // The pin is open drain: the data bit stays low and only the enable moves.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sleepPinOut <= 1'b0;
      sleepPinOe <= 1'b0;
    end
    else
    begin
      sleepPinOut <= 1'b0;
      sleepPinOe <= irqMode_q && irqPending;
    end
  end

  // Power-down is honoured only while the pin is an input; in the interrupt role a low
  // level is our own pull-down and must not put the device to sleep.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      powerDown <= 1'b0;
    end
    else
    begin
      powerDown <= !irqMode_q && !sleepPinIn;
    end
  end
endmodule
`default_nettype wire

// ---- hw/pmf_reset_filter.sv ----
`default_nettype none
`include "pmf_regs.svh"
module pmf_reset_filter (
  // Clock and raw reset.
  input wire logic core_clk,
  input wire logic nrst,
  // Qualified reset level and strap capture strobe.
  output logic hwResetQ,
  output logic strapLoad
);
  import pmf_pkg::*;
  logic [`PMF_RESET_CNT_W-1:0] lowCnt_q;
  logic rstMeta_q;
  logic rstSync_q;
  logic armed_q;
  logic atMin;

  assign atMin = (lowCnt_q == `PMF_RESET_CNT_W'(`PMF_RESET_MIN_CYC));

  // The reset input is synchronised so its low time can be counted.
  always_ff @(posedge core_clk)
  begin
    rstMeta_q <= nrst;
    rstSync_q <= rstMeta_q;
  end

  // A low period counts only once it reaches the minimum width.
  always_ff @(posedge core_clk)
  begin
    if (rstSync_q)
    begin
      lowCnt_q <= '0;
    end
    else if (lowCnt_q != `PMF_RESET_CNT_W'(`PMF_RESET_MIN_CYC))
    begin
      lowCnt_q <= lowCnt_q + `PMF_RESET_CNT_W'(1);
    end
  end

  // The arm flag outlives the counter clear at release, so a low time of exactly the
  // minimum still loads the straps, and the load strobe fires only once.
  always_ff @(posedge core_clk)
  begin
    armed_q <= atMin || (armed_q && !rstSync_q);
    hwResetQ <= atMin && !rstSync_q;
    strapLoad <= armed_q && rstSync_q && !atMin;
  end
endmodule
`default_nettype wire

// ---- pkg/pmf_pkg.sv ----
`default_nettype none
package pmf_pkg;
  typedef enum logic [2:0] {
    PMF_PIN_REFCLK = 3'h1,
    PMF_PIN_LED = 3'h2,
    PMF_PIN_GPIO = 3'h4
  } pmf_pin_role_t;
  typedef struct packed {
    logic en;
    logic [1:0] data;
  } pmf_tx_t;
  typedef struct packed {
    logic in;
    logic out;
    logic oe;
  } pmf_pad_t;
  typedef struct packed {
    logic gpioSel;
    logic gpioOut;
    logic gpioOe;
    logic irqModeWr;
    logic irqModeVal;
  } pmf_cfg_t;
endpackage
`default_nettype wire

// ---- pkg/pmf_regs.svh ----
`ifndef PMF_REGS_SVH
`define PMF_REGS_SVH
`define PMF_CLK_PERIOD_NS 8
`define PMF_RESET_MIN_NS 1000
`define PMF_RESET_MIN_CYC ((`PMF_RESET_MIN_NS + `PMF_CLK_PERIOD_NS - 1) / `PMF_CLK_PERIOD_NS)
`define PMF_RESET_CNT_W 8
`define PMF_PIN_FUNC_RST 2'h0
`define PMF_IRQ_MODE_RST 1'b0
`endif

// ---- tb/pmf_mac_model.sv ----
`default_nettype none
module pmf_mac_model (
  input wire logic core_clk,
  input wire logic go,
  input wire logic gap,
  output pmf_pkg::pmf_tx_t txIn = '0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] cnt = 2'h0;
  // Idle data keeps changing so a stale dibit is never mistaken for valid.
  always @(posedge core_clk)
  begin
    #1;
    txIn.en <= go & ~(gap & cnt[0]);
    txIn.data <= cnt;
    cnt <= cnt + 2'h1;
  end
endmodule
`default_nettype wire

// ---- tb/pmf_pin_logic_asserts.sv ----
`default_nettype none
module pmf_pin_chk (
  input wire logic core_clk,
  input wire logic nrst,
  input wire pmf_pkg::pmf_cfg_t cfg,
  input wire logic irqPending,
  input wire pmf_pkg::pmf_tx_t txIn,
  input wire logic txValid,
  input wire logic [1:0] txData,
  input wire pmf_pkg::pmf_pad_t refPad,
  input wire logic sleepPinIn,
  input wire logic sleepPinOut,
  input wire logic sleepPinOe,
  input wire logic powerDown
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_arm;
    cfg.irqModeWr && cfg.irqModeVal && irqPending ##1 irqPending[*2];
  endsequence
  sequence s_gsel;
    cfg.gpioSel[*4];
  endsequence
  property p_tx; $past(txIn.en) |-> txValid && txData == $past(txIn.data); endproperty
  property p_txz; !$past(txIn.en) |-> !txValid && txData == 2'h0; endproperty
  property p_od; sleepPinOut == 1'b0; endproperty
  property p_pd; powerDown |-> !$past(sleepPinIn); endproperty
  property p_pdx; sleepPinOe |-> !powerDown; endproperty
  property p_oe; $fell(irqPending) |=> !sleepPinOe; endproperty
  property p_arm; s_arm |-> sleepPinOe; endproperty
  property p_gp; s_gsel |-> refPad.oe == $past(cfg.gpioOe) && refPad.out == $past(cfg.gpioOut);
  endproperty
  a_tx: assert property (p_tx) else $error("tx data");
  a_txz: assert property (p_txz) else $error("tx idle");
  a_od: assert property (p_od) else $error("drive high");
  a_pd: assert property (p_pd) else $error("sleep");
  a_pdx: assert property (p_pdx) else $error("sleep in irq");
  a_oe: assert property (p_oe) else $error("irq held");
  a_arm: assert property (p_arm) else $error("irq off");
  a_gp: assert property (p_gp) else $error("gpio");
endmodule
bind pmf_pin_logic pmf_pin_chk i_chk(.*);
`default_nettype wire

// ---- tb/pmf_pin_logic_test.sv ----
`default_nettype none
module pmf_pin_logic_test;
  timeunit 1ns;
  timeprecision 1ns;
  import pmf_pkg::*;
  logic core_clk = 1'b0, nrst = 1'b0, strapMaster = 1'b0, irqPending = 1'b0, go = 1'b0;
  logic gap = 1'b0, refPinIn = 1'b0, sleepHold = 1'b0, refClkIn = 1'b1, ledIn = 1'b0;
  logic txValid, sleepPinOut, sleepPinOe, powerDown, gpioIn, masterMode;
  wire logic sleepPinIn;
  // The irq/sleep line has a pull-up; the device or the far side may pull it low.
  assign sleepPinIn = !((sleepPinOe && !sleepPinOut) || sleepHold);
  logic [1:0] txData;
  pmf_cfg_t cfg = '0;
  pmf_tx_t txIn, e;
  pmf_pad_t refPad;
  int badCount = 0, nTests = 0, cyc = 0;
  pmf_mac_model i_mac(.core_clk, .go, .gap, .txIn);
  pmf_pin_logic i_dut(.core_clk, .nrst, .strapMaster, .cfg, .irqPending, .txIn, .txValid,
    .txData, .refClkIn, .ledIn, .refPinIn, .refPad, .sleepPinIn, .sleepPinOut,
    .sleepPinOe, .powerDown, .gpioIn, .masterMode);
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 1000)
    begin
      badCount++;
      endSim();
    end
  end
  // ====================
  // Scenarios.
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  task automatic chk(input logic [2:0] got, input logic [2:0] exp);
    nTests++;
    if (got !== exp)
    begin
      badCount++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tTx(input logic g);
    go = 1'b1;
    gap = g;
    repeat (8)
    begin
      e = txIn;
      tick(1);
      chk({txValid, txData}, e.en ? {1'b1, e.data} : 3'h0);
    end
    go = 1'b0;
  endtask
  task automatic tIrq();
    irqPending = 1'b1;
    tick(2);
    chk({powerDown, sleepPinOe, sleepPinOut}, 3'h0);
    sleepHold = 1'b1;
    cfg = 5'h1;
    tick(3);
    chk({powerDown, sleepPinOe, sleepPinOut}, 3'h4);
    cfg = 5'h3;
    tick(1);
    cfg = '0;
    tick(3);
    chk({powerDown, sleepPinOe, sleepPinOut}, 3'h2);
    irqPending = 1'b0;
    tick(2);
    chk({powerDown, sleepPinOe, sleepPinOut}, 3'h0);
    sleepHold = 1'b0;
  endtask
  task automatic tPin(input logic m);
    nrst = 1'b0;
    strapMaster = m;
    tick(130);
    nrst = 1'b1;
    tick(10);
    chk({masterMode, refPad.out, refPad.oe}, {m, m, 1'b1});
    refClkIn = 1'b0;
    ledIn = 1'b1;
    tick(2);
    chk({masterMode, refPad.out, refPad.oe}, {m, ~m, 1'b1});
    refClkIn = 1'b1;
    ledIn = 1'b0;
    cfg = {1'b1, ~m, 1'b1, 2'h0};
    refPinIn = ~m;
    tick(4);
    chk({refPad.out, refPad.oe, gpioIn}, {~m, 1'b1, ~m});
    cfg = '0;
  endtask
  task automatic endSim();
    if (badCount == 0 && nTests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    tick(3);
    nrst = 1'b1;
    tTx(1'b0);
    tTx(1'b1);
    tIrq();
    tPin(1'b0);
    tPin(1'b1);
    endSim();
  end
endmodule
`default_nettype wire
